/* File: hw/pmtb_defs.vh */
/*
 Constants for the PWM master time base controller: register offsets,
 field positions, reset values, key words and timing figures.
 Assumes it is included by its bare name from the design file.
*/
`ifndef PMTB_DEFS_VH
`define PMTB_DEFS_VH

// Register byte addresses, one 32-bit word each
`define PMTB_OFS_TBCTL 6'h00
`define PMTB_OFS_PRESCALE 6'h04
`define PMTB_OFS_PERIOD 6'h08
`define PMTB_OFS_EVCMP 6'h0c
`define PMTB_OFS_KEY 6'h10
`define PMTB_OFS_OUTCTL 6'h14
`define PMTB_OFS_FLTCTL 6'h18
`define PMTB_OFS_CFG 6'h1c
`define PMTB_OFS_STATUS 6'h20
`define PMTB_OFS_DUTY 6'h24

// Time base control fields
`define PMTB_BIT_ENABLE 15
`define PMTB_BIT_HALT_IDLE 13
`define PMTB_BIT_EV_PEND 12
`define PMTB_BIT_EV_IRQ_EN 11
`define PMTB_BIT_IMM_LOAD 10
`define PMTB_BIT_SYNC_POL 9
`define PMTB_BIT_SYNC_OEN 8
`define PMTB_BIT_EXT_SYNC 7
`define PMTB_SRC_HI 6
`define PMTB_SRC_LO 4
`define PMTB_PS_HI 3
`define PMTB_PS_LO 0

// Sync source codes
`define PMTB_SRC_EXT1 3'h0
`define PMTB_SRC_TG16 3'h2
`define PMTB_SRC_TG17 3'h3

// Fault control fields
`define PMTB_FLT_EN_BIT 15
`define PMTB_FLT_MODE_HI 1
`define PMTB_FLT_MODE_LO 0
`define PMTB_FLT_MODE_LATCHED 2'h0
`define PMTB_FLT_MODE_CYCLE 2'h1
`define PMTB_FLT_MODE_OFF 2'h3

// Reset values
`define PMTB_RST_TBCTL 16'h0000
`define PMTB_RST_PERIOD 16'hfff8
`define PMTB_RST_FLTCTL 16'h8000
`define PMTB_RST_OUTCTL 16'h0000

// Unlock keys
`define PMTB_KEY1 16'habcd
`define PMTB_KEY2 16'h4321

// Clock figures
`define PMTB_CLK_PERIOD_PS 4000
`define PMTB_STEP_PS 7140

`endif

/* File: hw/pmtb_top.v */
/*
 PWM master time base controller: six complementary generators on one
 master time base, sync in/out, special event trigger with postscaler,
 latched safety fault at reset and key-protected output/fault registers.
 Assumes an Avalon-MM master on core_clk and asynchronous pins that are
 synchronised here before use.
*/
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
// Summary of operation
// [RQ1] Six generators drive complementary high/low pairs from one master time base.
// [RQ2] Enabled, asserted fault forces affected outputs to the programmed safe state.
// [RQ3] Each generator triggers ADC at a programmed count; special event trigger too. Here all six fire at half the shared duty count.
// [RQ4] Time base restarts on an external sync pulse and emits a sync pulse.
// [RQ5] Reset leaves the safety fault enabled in latched mode, outputs safe.
// [RQ6] Software clears the latched fault with the fault pin high before enabling.
// [RQ7] Fault mode field writable whatever the safety fault level.
// [RQ8] Output and fault control writes blocked while write protect is one.
// [RQ9] Keys 0xabcd then 0x4321 in consecutive writes unlock one write.
// [RQ10] Any access other than the protected write voids the unlock.
// [RQ11] Each unlock permits exactly one protected write.
// [RQ12] Control bit 15 enables the unit; reset value zero.
// [RQ13] Control bit 13 halts the time base while the CPU idles.
// [RQ14] Bit 12 shows pending special event; bit 11 enables its interrupt.
// [RQ15] Bit 10 loads the period at once, else at cycle boundary.
// [RQ16] Bit 9 makes sync input and output active low.
// [RQ17] Bit 8 enables sync output; bit 7 enables external sync.
// [RQ18] Bits 6..4 pick sync source: external, trigger outputs 16 or 17.
// [RQ19] Bits 3..0 postscale event matches; code 1111 gives every sixteenth.
// [RQ20] Code zero triggers every match; code n every n+1 matches.
// [RQ21] Software changes update, sync and postscale only while disabled.
// [RQ22] With external sync the period is set slightly longer than sync.
// [RQ23] Counts step once per prescaled clock, one step per resolution unit.
// [RQ24] Prescaler divides by 1..64 for codes 0..6; code 7 reserved.
// [RQ25] Counter held at zero when disabled, else counts to period and wraps.
`include "pmtb_defs.vh"

module pmtb_top #(
  parameter NGEN = 6,
  parameter CW = 16
) (
  input wire core_clk,
  input wire rstn,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire write_protect_cfg,
  input wire cpu_idle,
  input wire primary_sync_in,
  input wire trig_gen_out_sixteen,
  input wire trig_gen_out_seventeen,
  input wire safety_fault_in,
  output reg primary_sync_out,
  output reg [NGEN-1:0] high_side_out,
  output reg [NGEN-1:0] low_side_out,
  output reg [NGEN-1:0] adc_trig,
  output reg special_event_trig,
  output wire special_event_irq
);

  // Control, period and compare registers
  reg [15:0] tbctl_ff;
  reg [2:0] prescale_ff;
  reg [CW-1:0] period_ff;
  reg [CW-1:0] active_period_ff;
  reg [CW-1:0] evcmp_ff;
  reg [15:0] outctl_ff;
  reg [15:0] fltctl_ff;
  reg [CW-1:0] duty_ff;
  reg fault_latched_ff;
  reg [1:0] key_state_ff;
  reg [CW-1:0] tb_cnt_ff;
  reg [5:0] div_cnt_ff;
  reg [3:0] ps_cnt_ff;
  reg [2:0] sync_meta_ff;
  reg [2:0] sync_s_ff;
  reg sync_prev_ff;
  reg [1:0] flt_sync_ff;
  reg rd_pend_ff;

  wire enable = tbctl_ff[`PMTB_BIT_ENABLE];
  wire [2:0] src = tbctl_ff[`PMTB_SRC_HI:`PMTB_SRC_LO];
  wire [3:0] ps_code = tbctl_ff[`PMTB_PS_HI:`PMTB_PS_LO];
  wire wr = avs_write;
  wire rd = avs_read & ~rd_pend_ff;
  wire full_lo = avs_byteenable[0] & avs_byteenable[1];
  wire [15:0] wdat = avs_writedata[15:0];

  // Reads take one wait cycle so data comes from a flip-flop
  assign avs_waitrequest = avs_read & ~rd_pend_ff;

  // Pin synchronisers: first stage feeds only the second
  always @(posedge core_clk) begin
    if (!rstn) begin
      sync_meta_ff <= 3'h0;
      sync_s_ff <= 3'h0;
      flt_sync_ff <= 2'h3;
    end else begin
      sync_meta_ff <= {trig_gen_out_seventeen, trig_gen_out_sixteen, primary_sync_in};
      sync_s_ff <= sync_meta_ff;
      flt_sync_ff <= {flt_sync_ff[0], safety_fault_in};
    end
  end
  wire fault_active = ~flt_sync_ff[1]; // Safety fault pin is active low

  // Sync source select with polarity on the external pin only
  reg sync_sel;
  always @* begin
    sync_sel = 1'b0;
    if (src == `PMTB_SRC_EXT1) begin
      sync_sel = sync_s_ff[0] ^ tbctl_ff[`PMTB_BIT_SYNC_POL]; // [RQ16] [RQ18]
    end else if (src == `PMTB_SRC_TG16) begin
      sync_sel = sync_s_ff[1]; // [RQ18]
    end else if (src == `PMTB_SRC_TG17) begin
      sync_sel = sync_s_ff[2]; // [RQ18]
    end
  end
  wire sync_edge = sync_sel & ~sync_prev_ff & tbctl_ff[`PMTB_BIT_EXT_SYNC]; // [RQ17]

  // Prescaler tick; divide ratio 2**code, reserved code acts as 64
  wire [2:0] ps_eff = (prescale_ff == 3'h7) ? 3'h6 : prescale_ff;
  wire [5:0] div_max = (6'h01 << ps_eff) - 6'h01;
  wire halted = tbctl_ff[`PMTB_BIT_HALT_IDLE] & cpu_idle; // [RQ13]
  wire tick = enable & ~halted & (div_cnt_ff == div_max); // [RQ24] [RQ23]
  wire at_end = tick & (tb_cnt_ff >= active_period_ff);
  wire ev_match = tick & (tb_cnt_ff == evcmp_ff);
  wire ev_fire = ev_match & (ps_cnt_ff == ps_code); // [RQ19] [RQ20]

  // Key sequencer and protected write decode
  wire key_wr = wr & (avs_address == `PMTB_OFS_KEY);
  wire prot_wr = wr & ((avs_address == `PMTB_OFS_OUTCTL) | (avs_address == `PMTB_OFS_FLTCTL));
  wire unlocked = ~write_protect_cfg | (key_state_ff == 2'h2); // [RQ8]
  wire prot_ok = prot_wr & unlocked;

  // Bus access accepted this cycle; any one counts toward the key window
  wire access = wr | (avs_read & rd_pend_ff);

  always @(posedge core_clk) begin
    if (!rstn) begin
      key_state_ff <= 2'h0;
    end else if (access) begin
      if (key_wr && wdat == `PMTB_KEY1) begin
        key_state_ff <= 2'h1; // [RQ9]
      end else if (key_wr && wdat == `PMTB_KEY2 && key_state_ff == 2'h1) begin
        key_state_ff <= 2'h2; // [RQ9]
      end else begin
        key_state_ff <= 2'h0; // Spent or voided [RQ10] [RQ11]
      end
    end
  end

  // Register writes, event status and latched fault
  always @(posedge core_clk) begin
    if (!rstn) begin
      tbctl_ff <= `PMTB_RST_TBCTL; // [RQ12]
      prescale_ff <= 3'h0;
      period_ff <= `PMTB_RST_PERIOD;
      evcmp_ff <= {CW{1'b0}};
      outctl_ff <= `PMTB_RST_OUTCTL;
      fltctl_ff <= `PMTB_RST_FLTCTL; // Latched, enabled at reset [RQ5]
      duty_ff <= {CW{1'b0}};
      fault_latched_ff <= 1'b1; // Outputs come up safe [RQ5]
    end else begin
      if (wr && full_lo && avs_address == `PMTB_OFS_TBCTL) begin
        tbctl_ff[15:13] <= wdat[15:13] & 3'h5;
        tbctl_ff[11:0] <= wdat[11:0];
      end
      if (wr && full_lo && avs_address == `PMTB_OFS_PRESCALE) begin
        prescale_ff <= wdat[2:0];
      end
      if (wr && full_lo && avs_address == `PMTB_OFS_PERIOD) begin
        period_ff <= wdat[CW-1:0];
      end
      if (wr && full_lo && avs_address == `PMTB_OFS_EVCMP) begin
        evcmp_ff <= wdat[CW-1:0];
      end
      if (wr && full_lo && avs_address == `PMTB_OFS_DUTY) begin
        duty_ff <= wdat[CW-1:0];
      end
      if (prot_ok && full_lo && avs_address == `PMTB_OFS_OUTCTL) begin
        outctl_ff <= wdat; // [RQ8]
      end
      if (prot_ok && full_lo && avs_address == `PMTB_OFS_FLTCTL) begin
        fltctl_ff <= wdat; // [RQ8]
      end else if (prot_wr && full_lo && avs_address == `PMTB_OFS_FLTCTL) begin
        fltctl_ff[`PMTB_FLT_MODE_HI:`PMTB_FLT_MODE_LO] <= wdat[`PMTB_FLT_MODE_HI:`PMTB_FLT_MODE_LO]; // [RQ7]
      end
      // Pending flag: hardware set wins over a software clear of bit 12
      if (ev_fire) begin
        tbctl_ff[`PMTB_BIT_EV_PEND] <= 1'b1; // [RQ14]
      end else if (wr && full_lo && avs_address == `PMTB_OFS_TBCTL && !wdat[`PMTB_BIT_EV_PEND]) begin
        tbctl_ff[`PMTB_BIT_EV_PEND] <= 1'b0; // [RQ14]
      end
      // Latched fault sets on the pin, clears by writing status bit 0 with pin high
      if (fault_active && fltctl_ff[`PMTB_FLT_EN_BIT]) begin
        fault_latched_ff <= 1'b1; // [RQ2]
      end else if (wr && avs_address == `PMTB_OFS_STATUS && avs_byteenable[0] && wdat[0]) begin
        fault_latched_ff <= 1'b0; // [RQ6]
      end else if (fltctl_ff[`PMTB_FLT_MODE_HI:`PMTB_FLT_MODE_LO] == `PMTB_FLT_MODE_CYCLE && at_end) begin
        fault_latched_ff <= 1'b0; // Cycle-by-cycle mode releases at the boundary
      end
    end
  end

  wire flt_mode_off = fltctl_ff[`PMTB_FLT_MODE_HI:`PMTB_FLT_MODE_LO] == `PMTB_FLT_MODE_OFF;
  wire fault_force = fault_latched_ff & ~flt_mode_off & fltctl_ff[`PMTB_FLT_EN_BIT]; // [RQ2]

  // Master time base, prescaler, postscaler and period shadow
  always @(posedge core_clk) begin
    if (!rstn) begin
      tb_cnt_ff <= {CW{1'b0}};
      div_cnt_ff <= 6'h00;
      ps_cnt_ff <= 4'h0;
      active_period_ff <= `PMTB_RST_PERIOD;
      sync_prev_ff <= 1'b0;
    end else begin
      sync_prev_ff <= sync_sel;
      if (!enable) begin
        tb_cnt_ff <= {CW{1'b0}}; // [RQ25]
        div_cnt_ff <= 6'h00;
        ps_cnt_ff <= 4'h0;
        active_period_ff <= period_ff;
      end else begin
        if (!halted) begin
          div_cnt_ff <= (div_cnt_ff == div_max) ? 6'h00 : div_cnt_ff + 6'h01;
        end
        if (sync_edge) begin
          tb_cnt_ff <= {CW{1'b0}}; // Restart on external sync [RQ4] [RQ22]
        end else if (at_end) begin
          tb_cnt_ff <= {CW{1'b0}}; // [RQ25]
        end else if (tick) begin
          tb_cnt_ff <= tb_cnt_ff + {{(CW-1){1'b0}}, 1'b1}; // [RQ25]
        end
        if (tbctl_ff[`PMTB_BIT_IMM_LOAD] || at_end || sync_edge) begin
          active_period_ff <= period_ff; // [RQ15]
        end
        if (ev_match) begin
          ps_cnt_ff <= ev_fire ? 4'h0 : ps_cnt_ff + 4'h1; // [RQ19] [RQ20]
        end
      end
    end
  end

  // Sync out, event trigger and generator outputs
  // Generators share duty and all fire the same ADC trigger at half the duty count
  integer g;
  always @(posedge core_clk) begin
    if (!rstn) begin
      primary_sync_out <= 1'b0;
      special_event_trig <= 1'b0;
      high_side_out <= {NGEN{1'b0}};
      low_side_out <= {NGEN{1'b0}};
      adc_trig <= {NGEN{1'b0}};
    end else begin
      primary_sync_out <= (tbctl_ff[`PMTB_BIT_SYNC_OEN] & at_end) ^ tbctl_ff[`PMTB_BIT_SYNC_POL]; // [RQ4] [RQ16] [RQ17]
      special_event_trig <= ev_fire; // [RQ3]
      for (g = 0; g < NGEN; g = g + 1) begin
        adc_trig[g] <= tick & (tb_cnt_ff == (duty_ff >> 1)); // [RQ3]
        if (fault_force || !enable) begin
          high_side_out[g] <= outctl_ff[1]; // Safe override levels [RQ2]
          low_side_out[g] <= outctl_ff[0];
        end else begin
          high_side_out[g] <= tb_cnt_ff < duty_ff; // [RQ1]
          low_side_out[g] <= ~(tb_cnt_ff < duty_ff); // [RQ1]
        end
      end
    end
  end

  assign special_event_irq = tbctl_ff[`PMTB_BIT_EV_PEND] & tbctl_ff[`PMTB_BIT_EV_IRQ_EN]; // [RQ14]

  // Read mux; unmapped offsets read zero
  always @(posedge core_clk) begin
    if (!rstn) begin
      rd_pend_ff <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      rd_pend_ff <= rd;
      if (rd) begin
        if (avs_address == `PMTB_OFS_TBCTL) begin
          avs_readdata <= {16'h0000, tbctl_ff};
        end else if (avs_address == `PMTB_OFS_PRESCALE) begin
          avs_readdata <= {29'h00000000, prescale_ff};
        end else if (avs_address == `PMTB_OFS_PERIOD) begin
          avs_readdata <= {16'h0000, period_ff};
        end else if (avs_address == `PMTB_OFS_EVCMP) begin
          avs_readdata <= {16'h0000, evcmp_ff};
        end else if (avs_address == `PMTB_OFS_OUTCTL) begin
          avs_readdata <= {16'h0000, outctl_ff};
        end else if (avs_address == `PMTB_OFS_FLTCTL) begin
          avs_readdata <= {16'h0000, fltctl_ff};
        end else if (avs_address == `PMTB_OFS_CFG) begin
          avs_readdata <= {30'h00000000, key_state_ff == 2'h2, write_protect_cfg};
        end else if (avs_address == `PMTB_OFS_STATUS) begin
          avs_readdata <= {tb_cnt_ff, 13'h0000, fault_active, fault_force, fault_latched_ff};
        end else if (avs_address == `PMTB_OFS_DUTY) begin
          avs_readdata <= {16'h0000, duty_ff};
        end else begin
          avs_readdata <= 32'h00000000;
        end
      end
    end
  end

endmodule

/* File: verification/pmtb_far_side.sv */
/* Far-side model: safety fault pin with pull-up and a sync peer.
   Assumes commands from the bench on core_clk. */
module pmtb_far_side (
  input logic core_clk,
  input logic fault_cmd,
  input logic [1:0] sync_sel,
  input logic [7:0] sync_gap,
  output logic safety_fault_in,
  output logic primary_sync_in,
  output logic trig_gen_out_sixteen,
  output logic trig_gen_out_seventeen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] gap_ff = 8'h00;
  logic pulse;
  // Pull-up holds the pin high, so a latched fault can be cleared
  assign safety_fault_in = !fault_cmd;
  // Peer period kept shorter than the programmed one
  always @(posedge core_clk) begin
    gap_ff <= (gap_ff >= sync_gap) ? 8'h00 : gap_ff + 8'h01;
  end
  assign pulse = (sync_gap != 8'h00) && (gap_ff == 8'h00);
  // Only the chosen line pulses, the rest idle low
  assign primary_sync_in = pulse && sync_sel == 2'h1;
  assign trig_gen_out_sixteen = pulse && sync_sel == 2'h2;
  assign trig_gen_out_seventeen = pulse && sync_sel == 2'h3;
endmodule

/* File: verification/pmtb_properties.sv */
/* Port checker for the time base controller.
   Assumes it is bound into pmtb_top, one clock and sync reset. */
module pmtb_properties #(
  parameter NGEN = 6,
  parameter CW = 16
) (
  input logic core_clk,
  input logic rstn,
  input logic avs_read,
  input logic avs_write,
  input logic avs_waitrequest,
  input logic [31:0] avs_readdata,
  input logic safety_fault_in,
  input logic [NGEN-1:0] high_side_out,
  input logic [NGEN-1:0] low_side_out,
  input logic special_event_trig,
  input logic special_event_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Read handshake steps
  sequence s_rd_wait; avs_read && avs_waitrequest; endsequence
  sequence s_rd_done; avs_read && !avs_waitrequest; endsequence
  chk_read_wait: assert property ($rose(avs_read) |-> s_rd_wait)
    else $error("read not held off one cycle");
  chk_read_answer: assert property (s_rd_wait |=> s_rd_done)
    else $error("read not answered after one wait");
  chk_write_nowait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write was held off");
  chk_data_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  // Outputs stay safe right after reset and hold still during a fault
  chk_safe_start: assert property ($rose(rstn) |-> (high_side_out == 0 && low_side_out == 0) [*8])
    else $error("outputs left safe state after reset");
  chk_fault_hold: assert property (!safety_fault_in [*6] |-> $stable(high_side_out) && $stable(low_side_out))
    else $error("outputs moved during a fault");
  // Pending event only set by an event, cleared only by software
  chk_irq_rise: assert property ($rose(special_event_irq) |-> ($past(avs_write) || $past(special_event_trig)) or ##[0:1] special_event_trig)
    else $error("event interrupt rose without cause");
  chk_irq_fall: assert property ($fell(special_event_irq) |-> $past(avs_write))
    else $error("event interrupt dropped without a write");
endmodule
bind pmtb_top pmtb_properties #(.NGEN(NGEN), .CW(CW)) u_props (.core_clk(core_clk), .rstn(rstn),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
  .safety_fault_in(safety_fault_in), .high_side_out(high_side_out), .low_side_out(low_side_out),
  .special_event_trig(special_event_trig), .special_event_irq(special_event_irq));

/* File: verification/test_pmtb_top.sv */
/* Register-level tests of the time base controller.
   Assumes pmtb_top, its bound checker and the far-side model. */
`include "pmtb_defs.vh"
module test_pmtb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] TB = `PMTB_OFS_TBCTL, ST = `PMTB_OFS_STATUS, OC = `PMTB_OFS_OUTCTL, KY = `PMTB_OFS_KEY;
  logic core_clk = 0, rstn = 0, avs_read = 0, avs_write = 0, wp = 1, idle = 0, fault = 0;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, d, c;
  logic avs_waitrequest, sync_out, trig, irq, s16, s17, s_in, f_in;
  logic [1:0] sel = 2'h0;
  logic [7:0] gap = 8'h00;
  logic [5:0] hi, lo, adc;
  int mismatches = 0, compares = 0, cyc = 0, n_ev = 0, n_sy = 0, n_ad = 0, s, e, a;
  int ps[3] = '{0, 1, 15};
  pmtb_top dut (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .write_protect_cfg(wp), .cpu_idle(idle), .primary_sync_in(s_in),
    .trig_gen_out_sixteen(s16), .trig_gen_out_seventeen(s17), .safety_fault_in(f_in), .primary_sync_out(sync_out),
    .high_side_out(hi), .low_side_out(lo), .adc_trig(adc), .special_event_trig(trig), .special_event_irq(irq));
  pmtb_far_side far (.core_clk(core_clk), .fault_cmd(fault), .sync_sel(sel), .sync_gap(gap),
    .safety_fault_in(f_in), .primary_sync_in(s_in), .trig_gen_out_sixteen(s16), .trig_gen_out_seventeen(s17));
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // Pulse tallies and the hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    n_ev <= n_ev + trig;
    n_sy <= n_sy + sync_out;
    n_ad <= n_ad + adc[0];
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // One bus cycle; held until waitrequest is seen low
  task automatic acc(input logic we, input logic [5:0] ad, input logic [31:0] v);
    @(posedge core_clk);
    avs_address <= ad;
    avs_writedata <= v;
    avs_write <= we;
    avs_read <= !we;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rc(input logic [5:0] ad, input logic [31:0] exp);
    acc(1'b0, ad, 32'h0);
    chk(d, exp);
  endtask
  task automatic unlock();
    acc(1'b1, KY, `PMTB_KEY1);
    acc(1'b1, KY, `PMTB_KEY2);
  endtask
  // Settings changed only while the unit is off
  task automatic run(input logic [31:0] ctl, input int w);
    acc(1'b1, TB, 32'h0);
    acc(1'b1, TB, ctl);
    s = n_sy;
    e = n_ev;
    a = n_ad;
    repeat (w) @(posedge core_clk);
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    rc(TB, `PMTB_RST_TBCTL);
    rc(`PMTB_OFS_FLTCTL, `PMTB_RST_FLTCTL);
    rc(`PMTB_OFS_PERIOD, `PMTB_RST_PERIOD);
    acc(1'b0, ST, 32'h0);
    chk(d & 32'h3, 32'h3);
    $display("reset test done");
    // Locked: only the fault mode lands, with the pin tripped
    fault <= 1'b1;
    acc(1'b1, OC, 32'h3);
    rc(OC, 32'h0);
    acc(1'b1, `PMTB_OFS_FLTCTL, 32'h1);
    rc(`PMTB_OFS_FLTCTL, 32'h8001);
    acc(1'b1, `PMTB_OFS_FLTCTL, 32'h8000);
    acc(1'b1, ST, 32'h1);
    acc(1'b0, ST, 32'h0);
    chk(d & 32'h1, 32'h1);
    fault <= 1'b0;
    repeat (4) @(posedge core_clk);
    acc(1'b1, ST, 32'h1);
    acc(1'b0, ST, 32'h0);
    chk(d & 32'h1, 32'h0);
    $display("fault test done");
    // Keys: one write each, voided by any access, order matters
    unlock();
    acc(1'b1, OC, 32'h3);
    acc(1'b1, OC, 32'h0);
    rc(OC, 32'h3);
    unlock();
    rc(TB, 32'h0);
    acc(1'b1, OC, 32'h0);
    rc(OC, 32'h3);
    acc(1'b1, KY, `PMTB_KEY2);
    acc(1'b1, KY, `PMTB_KEY1);
    acc(1'b1, OC, 32'h0);
    rc(OC, 32'h3);
    wp <= 1'b0;
    acc(1'b1, OC, 32'h0);
    rc(OC, 32'h0);
    wp <= 1'b1;
    $display("lock test done");
    // Counter at zero while off, within period when on, frozen in idle
    acc(1'b1, `PMTB_OFS_PERIOD, 32'h9);
    acc(1'b1, `PMTB_OFS_EVCMP, 32'h3);
    acc(1'b1, `PMTB_OFS_DUTY, 32'h4);
    acc(1'b0, ST, 32'h0);
    chk(d >> 16, 32'h0);
    acc(1'b1, TB, 32'h8000);
    acc(1'b0, ST, 32'h0);
    chk(d[31:16] <= 16'h9, 32'h1);
    acc(1'b1, TB, 32'ha000);
    idle <= 1'b1;
    acc(1'b0, ST, 32'h0);
    c = d;
    rc(ST, c);
    acc(1'b1, TB, 32'h8000);
    acc(1'b0, ST, 32'h0);
    c = d;
    acc(1'b0, ST, 32'h0);
    chk(c != d, 32'h1);
    idle <= 1'b0;
    $display("time base test done");
    // Event postscaler: two triggers over 2*(code+1) match spans
    foreach (ps[i]) begin
      run(32'h8000 | ps[i], 20 * (ps[i] + 1));
      chk(n_ev - e, 32'h2);
    end
    // Writing 0 to the pending bit clears it; let events set it again
    acc(1'b1, TB, 32'h8000);
    repeat (20) @(posedge core_clk);
    rc(TB, 32'h9000);
    chk(irq, 32'h0);
    acc(1'b1, TB, 32'h9800);
    rc(TB, 32'h9800);
    chk(irq, 32'h1);
    acc(1'b1, TB, 32'h0);
    acc(1'b1, TB, 32'h0800);
    rc(TB, 32'h0800);
    chk(irq, 32'h0);
    $display("event test done");
    // Sync pulse and generator trigger per period, across prescaler codes
    for (int p = 0; p < 7; p++) begin
      acc(1'b1, TB, 32'h0);
      acc(1'b1, `PMTB_OFS_PRESCALE, p);
      // Second period end lands on the last edge, so allow its pulse to be tallied
      run(32'h8100, (20 << p) + 3);
      chk(n_sy - s, 32'h2);
      chk(n_ad - a, 32'h2);
    end
    acc(1'b1, TB, 32'h0);
    acc(1'b1, `PMTB_OFS_PRESCALE, 32'h0);
    run(32'h8300, 40);
    chk(n_sy - s, 32'h23);
    run(32'h8000, 40);
    chk(n_sy - s, 32'h0);
    $display("sync out test done");
    // Restart from each source; peer period under the long period
    acc(1'b1, `PMTB_OFS_PERIOD, 32'hff);
    gap <= 8'h28;
    for (int i = 0; i < 3; i++) begin
      sel <= 2'(i + 1);
      run(32'h8080 | ((i == 0 ? 32'h0 : i + 1) << 4), 120);
      acc(1'b0, ST, 32'h0);
      chk(d[31:16] < 16'h30, 32'h1);
      chk(hi ^ lo, 32'h3f);
    end
    gap <= 8'h00;
    $display("sync in test done");
    close_out();
  end
endmodule
